// ---- inc/sio_pkg.sv ----
package sio_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_OUT_IMAGE = 8'h04;
    localparam logic [7:0] REG_SAFE_OUT = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_ERR_CODE = 8'h10;
    localparam logic [7:0] REG_ERR_CLR = 8'h14;
    localparam logic [7:0] REG_SWITCHES = 8'h18;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Error code reported while the load supply is missing.
    localparam logic [15:0] ERR_LOAD_CODE = 16'h01F1;

    // Timing: a 1 ms tick is made from the 4 ns system clock.
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES_DEF = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam logic [1:0] FILTER_MS = 2'h3;
    localparam logic [9:0] FLASH_PERIOD_MS = 10'h3E8;
    localparam logic [9:0] SLOW_HALF_MS = 10'h1F4;
    localparam logic [9:0] FAST_HALF_MS = 10'h0FA;
    localparam logic [11:0] NODE_FLASH_MS = 12'hBB8;

    typedef enum logic [1:0] {
        MODE_PROTECTED,
        MODE_SETUP,
        MODE_FAILURE
    } sio_mode_e;

    typedef struct packed {
        logic [38:0] s1;
        logic [38:0] s2;
        logic latched;
        sio_mode_e mode;
        logic [1:0] mode_sw;
        logic [9:0] addr;
        logic [17:0] tick_cnt;
        logic [9:0] ms_cnt;
        logic [11:0] nf_cnt;
        logic [7:0] filt;
        logic [7:0][1:0] fcnt;
        logic [3:0] ctrl;
        logic [7:0] out_img;
        logic [3:0] safe_req;
        logic err_rsvd;
        logic err_mode;
        logic awv;
        logic wv;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] link_led;
        logic [1:0] act_led;
        logic [1:0] optic_led;
        logic [1:0] pulse_led;
        logic [1:0] pulse_en;
        logic [7:0] in_led;
        logic [3:0] out_on;
        logic [3:0] out_grn;
        logic [3:0] out_red;
        logic fs_red;
        logic comm_led;
        logic sf_led;
        logic comm_en;
        logic superv_en;
    } sio_state_s;

endpackage : sio_pkg

// ---- src/sio_top.sv ----
`timescale 1ns/100ps

// Contract
// - Green link indicator lit per port while that port has a connection.
// - Yellow activity indicator lit per port while frames move on it.
// - Node flash request flashes link and activity together, looking orange.
// - Optic indicator off above 2 dB, flashing 0 to 2 dB, on below 0 dB.
// - Pulse-supply indicator flashes 1 Hz on input cross circuit, else off.
// - Pulse-supply indicator steady on for supply short or overload.
// - Safe output indicator off/green; red on fault with output forced off.
// - Hardware fault gives steady red safety state and disables safe comms.
// - Safety state flashes red unparameterised; off when valid with supply.
// - Safe comm indicator off idle, green running, flashing on ack request.
// - Ten bit safety address read once at power-up, later changes ignored.
// - Mode bits: both off protected, both on setup, mixed is failure.
// - Mode sampled at power-up; a later change is flagged as error.
// - Setup mode exchanges one input byte and one output byte.
// - Setup input byte bits 0 to 7 carry safe inputs 0 to 7.
// - Setup output bit 0 powers modules, bits 1 to 3 valve zones.
// - Output bits 4 to 7 must be zero; nonzero raises an error.
// - Setup mode evaluates inputs singly with a 3 ms filter.
// - Setup mode disables pulse supplies and all input/output supervision.
// - Safe input indicator lit while its input is on.
// - Missing load supply flashes system fault and reports code 0x01F1 while missing.
module sio_top
    import sio_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic aclk, // System clock, 250 MHz.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte enables.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready, // Read data ready.
    input wire logic [1:0] port_link, // Link up per network port.
    input wire logic [1:0] port_activity, // Frames moving per port.
    input wire logic [1:0] optic_above_2db, // Optic level above 2 dB.
    input wire logic [1:0] optic_above_0db, // Optic level above 0 dB.
    input wire logic [1:0] cross_circuit, // Cross circuit per pulse supply.
    input wire logic [1:0] pulse_short, // Short or overload per supply.
    input wire logic [7:0] safe_input_pins, // Raw safe inputs.
    input wire logic [3:0] out_fault, // Fault per safe output.
    input wire logic hw_fault, // Hardware fault detected.
    input wire logic logic_supply_ok, // Logic supply present.
    input wire logic load_supply_ok, // Load supply above dropout.
    input wire logic [9:0] safety_addr_switch, // Safety address switch.
    input wire logic [1:0] mode_select_switch, // Mode switch bits 1 and 2.
    output logic [1:0] link_led, // Green link indicator per port.
    output logic [1:0] act_led, // Yellow activity indicator per port.
    output logic [1:0] optic_level_indicator, // Optic level indicator.
    output logic [1:0] pulse_led, // Pulse-supply indicators a and b.
    output logic pulse_supply_a, // Pulse supply a enable.
    output logic pulse_supply_b, // Pulse supply b enable.
    output logic [7:0] safe_input_indicators, // Safe input indicators.
    output logic [3:0] safe_out_on, // Module supply, valve_zone_outputs.
    output logic [3:0] safe_out_green, // Output indicator green.
    output logic [3:0] safe_out_red, // Output indicator red.
    output logic safety_state_indicator, // Red safety-state indicator.
    output logic safe_comm_led, // Green safe communication indicator.
    output logic system_fault_indicator, // Red system fault indicator.
    output logic safe_comm_enable, // Safe communication permitted.
    output logic supervision_enable // Cross, discrepancy, feedback checks.
);

    sio_state_s st;
    sio_state_s next_st;

    logic [1:0] sy_link;
    logic [1:0] sy_act;
    logic [1:0] sy_opt2;
    logic [1:0] sy_opt0;
    logic [1:0] sy_cross;
    logic [1:0] sy_short;
    logic [7:0] sy_in;
    logic [3:0] sy_ofault;
    logic sy_hw;
    logic sy_logic_ok;
    logic sy_load_ok;
    logic [9:0] sy_addr;
    logic [1:0] sy_mode;

    // Second synchroniser stage unpacked into named pin levels.
    assign {sy_link, sy_act, sy_opt2, sy_opt0, sy_cross, sy_short, sy_in,
            sy_ofault, sy_hw, sy_logic_ok, sy_load_ok, sy_addr,
            sy_mode} = st.s2;

    // All state is advanced here; outputs are flops of the same struct.
    always_comb begin
        logic tick;
        logic slow_ph;
        logic fast_ph;
        logic nflash;
        logic setup;
        logic fail;
        logic wr_go;
        logic [3:0] clr;
        logic [31:0] rd;
        logic rd_ok;
        next_st = st;
        tick = 1'b0;
        clr = 4'h0;
        rd = 32'h0;
        rd_ok = 1'b1;

        // Pins cross into the clock domain through two flops.
        next_st.s1 = {port_link, port_activity, optic_above_2db,
                      optic_above_0db, cross_circuit, pulse_short,
                      safe_input_pins, out_fault, hw_fault,
                      logic_supply_ok, load_supply_ok,
                      safety_addr_switch, mode_select_switch};
        next_st.s2 = st.s1;

        // Switches are taken once after reset, only after both sync stages
        // have refilled, or the cleared stages would be latched instead.
        // This needs TICK_CYCLES above two, which any real rate gives.
        if (!st.latched && (st.tick_cnt == 18'h2)) begin
            next_st.latched = 1'b1;
            next_st.addr = sy_addr;
            next_st.mode_sw = sy_mode;
            unique case (sy_mode)
                2'b00: next_st.mode = MODE_PROTECTED;
                2'b11: next_st.mode = MODE_SETUP;
                default: next_st.mode = MODE_FAILURE;
            endcase
        end

        // Prescaler: 1 ms tick and a millisecond phase for flashing.
        if (st.tick_cnt == 18'(TICK_CYCLES - 1)) begin
            next_st.tick_cnt = 18'h0;
            tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 18'h1;
        end
        if (tick) begin
            if (st.ms_cnt == FLASH_PERIOD_MS - 10'h1) begin
                next_st.ms_cnt = 10'h0;
            end else begin
                next_st.ms_cnt = st.ms_cnt + 10'h1;
            end
            if (st.nf_cnt != 12'h0) begin
                next_st.nf_cnt = st.nf_cnt - 12'h1;
            end
        end
        slow_ph = st.ms_cnt < SLOW_HALF_MS;
        fast_ph = (st.ms_cnt < FAST_HALF_MS) ||
                  ((st.ms_cnt >= SLOW_HALF_MS) &&
                   (st.ms_cnt < SLOW_HALF_MS + FAST_HALF_MS));
        nflash = st.nf_cnt != 12'h0;
        setup = st.latched && (st.mode == MODE_SETUP);
        fail = !st.latched || (st.mode == MODE_FAILURE);

        // Each input flips only after holding its new level for 3 ms.
        for (int i = 0; i < 8; i++) begin
            if (sy_in[i] == st.filt[i]) begin
                next_st.fcnt[i] = 2'h0;
            end else if (tick) begin
                if (st.fcnt[i] == FILTER_MS - 2'h1) begin
                    next_st.filt[i] = sy_in[i];
                    next_st.fcnt[i] = 2'h0;
                end else begin
                    next_st.fcnt[i] = st.fcnt[i] + 2'h1;
                end
            end
        end

        // Write channel: address and data are taken in either order.
        if (s_axi_awvalid && st.awready) begin
            next_st.awv = 1'b1;
            next_st.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.wv = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        wr_go = st.awv && st.wv && !st.bvalid;
        if (wr_go) begin
            next_st.awv = 1'b0;
            next_st.wv = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            unique case (st.waddr)
                REG_CTRL: begin
                    if (st.wstrb[0]) begin
                        next_st.ctrl = st.wdata[3:0];
                        if (st.wdata[4]) begin
                            next_st.nf_cnt = NODE_FLASH_MS;
                        end
                    end
                end
                REG_OUT_IMAGE: begin
                    if (st.wstrb[0]) begin
                        next_st.out_img = st.wdata[7:0];
                    end
                end
                REG_SAFE_OUT: begin
                    if (st.wstrb[0]) begin
                        next_st.safe_req = st.wdata[3:0];
                    end
                end
                REG_ERR_CLR: begin
                    if (st.wstrb[0]) begin
                        clr = st.wdata[3:0];
                    end
                end
                REG_STATUS, REG_ERR_CODE, REG_SWITCHES: begin
                    next_st.bresp = RESP_OKAY;
                end
                default: next_st.bresp = RESP_SLVERR;
            endcase
        end
        next_st.awready = !next_st.awv && !next_st.bvalid;
        next_st.wready = !next_st.wv && !next_st.bvalid;

        // Sticky errors: a new event wins over a clear in the same cycle.
        next_st.err_rsvd = (st.err_rsvd && !clr[0]) ||
            (wr_go && setup && (st.waddr == REG_OUT_IMAGE) &&
             st.wstrb[0] && (st.wdata[7:4] != 4'h0));
        next_st.err_mode = (st.err_mode && !clr[1]) ||
            (st.latched && (sy_mode != st.mode_sw));

        // Read channel: one cycle from address to data.
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            unique case (s_axi_araddr)
                REG_CTRL: rd = {28'h0, st.ctrl};
                REG_OUT_IMAGE: rd = {24'h0, st.out_img};
                REG_SAFE_OUT: rd = {28'h0, st.safe_req};
                REG_STATUS: rd = {15'h0, st.comm_en, sy_hw, fail,
                                  st.err_mode, st.err_rsvd, st.out_on,
                                  st.filt};
                REG_ERR_CODE: rd = {16'h0, sy_load_ok ? 16'h0 :
                                    ERR_LOAD_CODE};
                REG_SWITCHES: rd = {14'h0, st.mode, 6'h0, st.addr};
                REG_ERR_CLR: rd = 32'h0;
                default: rd_ok = 1'b0;
            endcase
            next_st.rvalid = 1'b1;
            next_st.rdata = rd;
            next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
        next_st.arready = !next_st.rvalid;

        // Network port indicators; node flash overrides both colours.
        for (int p = 0; p < 2; p++) begin
            next_st.link_led[p] = nflash ? fast_ph : sy_link[p];
            next_st.act_led[p] = nflash ? fast_ph : sy_act[p];
            if (sy_opt2[p]) begin
                next_st.optic_led[p] = 1'b0;
            end else if (sy_opt0[p]) begin
                next_st.optic_led[p] = fast_ph;
            end else begin
                next_st.optic_led[p] = 1'b1;
            end
        end

        // Pulse supplies run only in protected operation.
        next_st.pulse_en = (!fail && !setup) ? 2'h3 : 2'h0;
        next_st.superv_en = !fail && !setup;
        for (int p = 0; p < 2; p++) begin
            if (sy_short[p]) begin
                next_st.pulse_led[p] = 1'b1;
            end else if (sy_cross[p] && next_st.superv_en) begin
                next_st.pulse_led[p] = slow_ph;
            end else begin
                next_st.pulse_led[p] = 1'b0;
            end
        end
        next_st.in_led = st.filt;

        // Safe outputs: a fault forces the output off and shows red.
        for (int o = 0; o < 4; o++) begin
            logic req;
            req = setup ? st.out_img[o] : st.safe_req[o];
            req = req && !fail && !sy_hw && !(setup && st.err_rsvd);
            next_st.out_on[o] = req && !sy_ofault[o];
            next_st.out_red[o] = sy_ofault[o];
            next_st.out_grn[o] = next_st.out_on[o];
        end

        // Safety state and communication permission.
        next_st.comm_en = !sy_hw && !fail;
        if (sy_hw || fail) begin
            next_st.fs_red = 1'b1;
        end else if (st.ctrl[0] && !st.ctrl[1] && sy_logic_ok) begin
            next_st.fs_red = 1'b0;
        end else begin
            next_st.fs_red = fast_ph;
        end
        if (!st.ctrl[2] || !next_st.comm_en) begin
            next_st.comm_led = 1'b0;
        end else if (st.ctrl[3]) begin
            next_st.comm_led = slow_ph;
        end else begin
            next_st.comm_led = 1'b1;
        end
        if (!sy_load_ok) begin
            next_st.sf_led = fast_ph;
        end else begin
            next_st.sf_led = sy_hw || fail;
        end
    end

    // Reset clears every field, so all outputs start low and idle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign link_led = st.link_led;
    assign act_led = st.act_led;
    assign optic_level_indicator = st.optic_led;
    assign pulse_led = st.pulse_led;
    assign pulse_supply_a = st.pulse_en[0];
    assign pulse_supply_b = st.pulse_en[1];
    assign safe_input_indicators = st.in_led;
    assign safe_out_on = st.out_on;
    assign safe_out_green = st.out_grn;
    assign safe_out_red = st.out_red;
    assign safety_state_indicator = st.fs_red;
    assign safe_comm_led = st.comm_led;
    assign system_fault_indicator = st.sf_led;
    assign safe_comm_enable = st.comm_en;
    assign supervision_enable = st.superv_en;

endmodule : sio_top

// ---- bench/sio_net_model.sv ----
`timescale 1ns/100ps
// Network side of the block: per-port link state and frame traffic.
module sio_net_model (
    input wire logic aclk, // System clock.
    input wire logic [1:0] link_cmd, // Ports to bring up.
    input wire logic [1:0] traffic_cmd, // Ports asked to carry frames.
    output logic [1:0] port_link, // Link status to the block.
    output logic [1:0] port_activity // Frame activity to the block.
);
    initial port_link = 2'h0;
    initial port_activity = 2'h0;
    // Frames only move on a port whose link is up, as on a real cable.
    always @(posedge aclk) begin
        port_link <= link_cmd;
        port_activity <= traffic_cmd & link_cmd;
    end
endmodule : sio_net_model

// ---- bench/sio_top_monitor.sv ----
`timescale 1ns/100ps
// Port-level checker for the status block.
module sio_top_monitor
    import sio_pkg::*;
#(
    parameter int TICK_CYCLES = 10
) (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic [1:0] port_link, // Link per port.
    input wire logic [1:0] port_activity, // Activity per port.
    input wire logic [1:0] optic_above_2db, // Optic above 2 dB.
    input wire logic [1:0] optic_above_0db, // Optic above 0 dB.
    input wire logic [1:0] pulse_short, // Supply short.
    input wire logic [7:0] safe_input_pins, // Raw inputs.
    input wire logic hw_fault, // Hardware fault.
    input wire logic [1:0] link_led, // Link indicator.
    input wire logic [1:0] act_led, // Activity indicator.
    input wire logic [1:0] optic_level_indicator, // Optic indicator.
    input wire logic [1:0] pulse_led, // Pulse-supply indicator.
    input wire logic [7:0] safe_input_indicators, // Input indicators.
    input wire logic [3:0] safe_out_on, // Output state.
    input wire logic [3:0] safe_out_red, // Output red.
    input wire logic safety_state_indicator, // Safety state red.
    input wire logic safe_comm_enable // Safe comms permitted.
);
    logic [2:0] rcnt;
    logic [7:0] prev_in;
    logic [15:0] scnt;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Age since reset and since inputs moved; $past must not see reset.
    always_ff @(posedge aclk) begin
        prev_in <= safe_input_pins;
        if (!aresetn) begin
            rcnt <= 3'h0;
            scnt <= 16'h0000;
        end else begin
            rcnt <= (rcnt == 3'h7) ? rcnt : rcnt + 3'h1;
            if (safe_input_pins != prev_in) scnt <= 16'h0000;
            else if (scnt != 16'hFFFF) scnt <= scnt + 16'h0001;
        end
    end
    a_link_follow: assert property (rcnt == 3'h7 |->
        link_led == $past(port_link, 3)) else $error("link led wrong");
    a_act_follow: assert property (rcnt == 3'h7 |->
        act_led == $past(port_activity, 3)) else $error("act led wrong");
    a_optic_dark: assert property (rcnt == 3'h7 &&
        $past(optic_above_2db[0], 3) |-> !optic_level_indicator[0])
        else $error("optic led not off");
    a_optic_lit: assert property (rcnt == 3'h7 &&
        !$past(optic_above_0db[0], 3) |-> optic_level_indicator[0])
        else $error("optic led not on");
    a_short_lit: assert property (rcnt == 3'h7 &&
        $past(pulse_short[1], 3) |-> pulse_led[1])
        else $error("short led not on");
    a_red_off: assert property ((safe_out_red & safe_out_on) == 4'h0)
        else $error("red output still on");
    a_fault_red: assert property (rcnt == 3'h7 && $past(hw_fault, 3)
        |-> safety_state_indicator && !safe_comm_enable)
        else $error("hardware fault not shown");
    a_input_led: assert property (scnt > 5 * TICK_CYCLES + 8 |->
        safe_input_indicators == safe_input_pins)
        else $error("input led wrong");
endmodule : sio_top_monitor

bind sio_top sio_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_sio_top_monitor (
    .aclk(aclk), .aresetn(aresetn), .port_link(port_link),
    .port_activity(port_activity), .optic_above_2db(optic_above_2db),
    .optic_above_0db(optic_above_0db), .pulse_short(pulse_short),
    .safe_input_pins(safe_input_pins), .hw_fault(hw_fault),
    .link_led(link_led), .act_led(act_led),
    .optic_level_indicator(optic_level_indicator), .pulse_led(pulse_led),
    .safe_input_indicators(safe_input_indicators),
    .safe_out_on(safe_out_on), .safe_out_red(safe_out_red),
    .safety_state_indicator(safety_state_indicator),
    .safe_comm_enable(safe_comm_enable));

// ---- bench/sio_top_tb_top.sv ----
`timescale 1ns/100ps
module sio_top_tb_top;
    import sio_pkg::*;
    localparam int TICK = 10;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, hwf = 1'b0, loadok = 1'b1;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0, ofault = 4'h0;
    logic [1:0] link_cmd = 2'h0, traffic_cmd = 2'h0, pshort = 2'h0;
    logic [1:0] opt2 = 2'h3, opt0 = 2'h3;
    logic [7:0] pins = 8'h00;
    logic [9:0] addr_sw = 10'h155;
    logic [1:0] mode_sw = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, fs, comm_en;
    logic [1:0] bresp, rresp, plink, pact, link_led, act_led, optic, pled;
    logic [31:0] rdata, rd;
    logic [7:0] in_led;
    logic [3:0] out_on, out_grn, out_red;
    logic [1:0] resp;
    int fail_count = 0;
    int num_checks = 0;

    // Free-running system clock, 4 ns period.
    always #2 aclk = ~aclk;

    sio_net_model i_sio_net_model (.aclk(aclk), .link_cmd(link_cmd),
        .traffic_cmd(traffic_cmd), .port_link(plink), .port_activity(pact));

    // Short tick keeps flash and filter times within a brief run.
    sio_top #(.TICK_CYCLES(TICK)) i_sio_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .port_link(plink), .port_activity(pact),
        .optic_above_2db(opt2), .optic_above_0db(opt0),
        .cross_circuit(2'h0), .pulse_short(pshort), .safe_input_pins(pins),
        .out_fault(ofault), .hw_fault(hwf), .logic_supply_ok(1'b1),
        .load_supply_ok(loadok), .safety_addr_switch(addr_sw),
        .mode_select_switch(mode_sw), .link_led(link_led), .act_led(act_led),
        .optic_level_indicator(optic), .pulse_led(pled),
        .pulse_supply_a(), .pulse_supply_b(),
        .safe_input_indicators(in_led), .safe_out_on(out_on),
        .safe_out_green(out_grn), .safe_out_red(out_red),
        .safety_state_indicator(fs), .safe_comm_led(),
        .system_fault_indicator(), .safe_comm_enable(comm_en),
        .supervision_enable());

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    // Write cycle: address and data offered together, each let go when taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (awready === 1'b1) ad = 1'b1;
            if (wready === 1'b1) wd = 1'b1;
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    // Read cycle: data and response taken at the edge where rvalid is high.
    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // Switches are only looked at once; later moves must not show.
    task automatic t_switches;
        axi_rd(REG_SWITCHES);
        chk(rd[17:0], 32'h155);
        @(posedge aclk) addr_sw <= 10'h2AA;
        cyc(10);
        axi_rd(REG_SWITCHES);
        chk(rd[9:0], 32'h155);
        axi_wr(8'h40, 32'h1);
        chk(resp, RESP_SLVERR);
        axi_rd(8'h40);
        chk({rd, resp}, {32'h0, RESP_SLVERR});
    endtask : t_switches

    task automatic t_indicators;
        @(posedge aclk);
        link_cmd <= 2'h1;
        traffic_cmd <= 2'h3;
        opt2 <= 2'h0;
        opt0 <= 2'h0;
        pshort <= 2'h2;
        cyc(8);
        chk(link_led, 2'h1);
        chk(act_led, 2'h1);
        chk(optic, 2'h3);
        chk(pled, 2'h2);
        opt2 <= 2'h3;
        opt0 <= 2'h3;
        pshort <= 2'h0;
        link_cmd <= 2'h0;
        cyc(8);
        chk({link_led, act_led, optic}, 6'h00);
        chk(pled, 2'h0);
    endtask : t_indicators

    // A faulted output shows red and stays off while the others run.
    task automatic t_outputs;
        @(posedge aclk);
        pins <= 8'hA5;
        ofault <= 4'h2;
        axi_wr(REG_SAFE_OUT, 32'hF);
        cyc(6 * TICK + 10);
        chk(in_led, 8'hA5);
        chk({out_on, out_grn, out_red}, 12'hDD2);
        ofault <= 4'h0;
    endtask : t_outputs

    task automatic t_faults;
        @(posedge aclk) loadok <= 1'b0;
        cyc(8);
        axi_rd(REG_ERR_CODE);
        chk(rd, {16'h0, ERR_LOAD_CODE});
        loadok <= 1'b1;
        hwf <= 1'b1;
        cyc(8);
        axi_rd(REG_ERR_CODE);
        chk(rd, 32'h0);
        chk({fs, comm_en}, 2'h2);
        @(posedge aclk) hwf <= 1'b0;
    endtask : t_faults

    // Setup mode needs a fresh reset; reserved bits block all outputs.
    task automatic t_setup;
        @(posedge aclk);
        mode_sw <= 2'h3;
        aresetn <= 1'b0;
        cyc(3);
        aresetn <= 1'b1;
        cyc(2);
        axi_rd(REG_SWITCHES);
        chk(rd[17:16], 32'h1);
        axi_wr(REG_OUT_IMAGE, 32'h13);
        cyc(4);
        chk(out_on, 4'h0);
        axi_rd(REG_STATUS);
        chk(rd[12], 1'b1);
        axi_wr(REG_ERR_CLR, 32'h1);
        axi_wr(REG_OUT_IMAGE, 32'h5);
        cyc(4);
        chk(out_on, 4'h5);
    endtask : t_setup

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test

    // Reset for three edges, then run each scenario in turn.
    initial begin
        cyc(3);
        aresetn <= 1'b1;
        cyc(2);
        t_switches();
        t_indicators();
        t_outputs();
        t_faults();
        t_setup();
        end_of_test();
    end

    // The scenarios need well under a thousand cycles; a hang ends here.
    initial begin
        cyc(20000);
        fail_count++;
        end_of_test();
    end
endmodule : sio_top_tb_top
